// >>> hdl/brs_pkg.sv
// package: shared constants and carrier types for the bypass router selector
package brs_pkg;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 10000000;
  localparam int unsigned FILTER_TIME_US  = 2;      // contact debounce settle time
  localparam int unsigned FILTER_CYCLES   = (FILTER_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned FILTER_CNT_W    = 8;
  localparam logic        RST_SEL_SECOND  = 1'b0;   // program starts on input one
  localparam logic        RST_AUTO_SECOND = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BRS_STD_NONE, BRS_STD_SD, BRS_STD_HD} brs_std_t;
  typedef enum logic [1:0] {BRS_REF_NONE, BRS_REF_BLACK, BRS_REF_TRI} brs_ref_t;

  // per-input status reported by the line front ends
  typedef struct packed {
    logic valid;       // valid video present
    logic rate_hd;     // 1 = 1.485 Gb/s seen, 0 = 270 Mb/s
    logic [1:0] audio; // embedded audio groups one and two present
  } brs_in_stat_t;

  // routing decision handed to the crosspoint
  typedef struct packed {
    logic     pgm_second;   // program from input two
    logic     prev_second;  // preview from input two
    brs_std_t pgm_std;
    brs_std_t prev_std;
    logic     mon_bypass;   // monitor outputs carry direct copies
    logic [1:0] mon_pgm_audio;
    logic [1:0] mon_prev_audio;
  } brs_route_t;

endpackage

// >>> hdl/brs_contact_filter.sv
// module: three-stage synchroniser and debounce for one active-low contact input
module brs_contact_filter #(
  parameter int unsigned CYCLES = brs_pkg::FILTER_CYCLES
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic contact_n_in,
  output logic      active_out,
  output logic      press_out
);
  logic [2:0] sync_q;
  logic [brs_pkg::FILTER_CNT_W-1:0] cnt_q;
  logic stable_q;
  logic agree;
  logic differ;
  logic done;

  // settled sample: second and third stages agree, low means asserted
  assign agree  = (sync_q[1] == sync_q[2]);
  assign differ = agree && (~sync_q[2] != stable_q);
  assign done   = (cnt_q == brs_pkg::FILTER_CNT_W'(CYCLES - 1));

  // synchroniser chain, idle high as the pull-up leaves it
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sync_q <= 3'h7;
    else
      sync_q <= {sync_q[1:0], contact_n_in};
  end

  // a new level must hold for the filter time before it is taken
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q    <= '0;
      stable_q <= 1'b0;
      press_out <= 1'b0;
    end
    else
    begin
      press_out <= 1'b0;
      if (!differ)
        cnt_q <= '0;
      else if (done)
      begin
        cnt_q    <= '0;
        stable_q <= ~sync_q[2];
        press_out <= ~sync_q[2]; // one pulse per activation
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign active_out = stable_q;

  chk_one_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    press_out |=> !press_out) else $error("press pulse longer than one cycle");
endmodule

// >>> hdl/brs_select_ctrl.sv
// module: program and preview selection control with contact inputs and tallies
// How it works
// - input one is the program source, input two the backup or preview source.
// - selected program source drives all three program outputs, same standard.
// - preview output carries the non-program source in its own standard.
// - contact inputs are active low; open input reads inactive.
// - manual mode: press on first input puts input one on program.
// - manual mode: press on second input puts input two on program.
// - automatic mode: a held contact forces its routing regardless of quality.
// - both contacts high or both low keeps automatic switching.
// - first tally high for input one on program, second for input two.
// - each input rate, SD or HD, is detected without configuration.
// - reference type, colour black or tri-level, is detected automatically.
// - SD program and preview bypass downconverters onto monitor outputs.
// - monitor outputs carry two audio groups from their respective inputs.
module brs_select_ctrl (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  select_first_in,
  input  wire logic                  select_second_in,
  input  wire logic                  switch_mode_setting_in, // 1 = automatic
  input  wire brs_pkg::brs_in_stat_t stat_first_in,
  input  wire brs_pkg::brs_in_stat_t stat_second_in,
  input  wire logic                  ref_present_in,
  input  wire logic                  ref_tri_level_in,
  output brs_pkg::brs_route_t        route_out,
  output brs_pkg::brs_ref_t          ref_type_out,
  output logic [2:0]                 program_output_sel_out,
  output logic                       tally_first_out,
  output logic                       tally_second_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // asynchronous assert, two-flop synchronous release
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // contact inputs
  // ----------------------------------------------------------------
  logic first_active;
  logic first_press;
  logic second_active;
  logic second_press;

  brs_contact_filter u_first (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n),
    .contact_n_in (select_first_in),
    .active_out   (first_active),
    .press_out    (first_press)
  );

  brs_contact_filter u_second (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n),
    .contact_n_in (select_second_in),
    .active_out   (second_active),
    .press_out    (second_press)
  );

  // mode level from a strap pin: three flops, change once stages agree
  logic [2:0] mode_sync_q;
  logic       auto_mode_q;
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_sync_q <= 3'h0;
      auto_mode_q <= 1'b0;
    end
    else
    begin
      mode_sync_q <= {mode_sync_q[1:0], switch_mode_setting_in};
      if (mode_sync_q[1] == mode_sync_q[2])
        auto_mode_q <= mode_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // selection decision
  // ----------------------------------------------------------------
  logic sel_second_q;
  logic sel_second_d;
  logic force_first;
  logic force_second;
  logic auto_second;
  logic first_good;
  logic second_good;

  assign first_good   = stat_first_in.valid;
  assign second_good  = stat_second_in.valid;
  assign force_first  = first_active && !second_active;
  assign force_second = second_active && !first_active;
  // automatic choice: leave a failed program for a good backup, return only when input one is good and input two has failed
  assign auto_second  = sel_second_q ? !(first_good && !second_good) || !first_good
                                        && second_good
                                     : (!first_good && second_good);

  // next program source
  always_comb
  begin
    sel_second_d = sel_second_q;
    if (!auto_mode_q)
    begin
      if (first_press)
        sel_second_d = 1'b0;
      else if (second_press)
        sel_second_d = 1'b1;
    end
    else if (force_first)
      sel_second_d = 1'b0;
    else if (force_second)
      sel_second_d = 1'b1;
    else
      sel_second_d = auto_second;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      sel_second_q <= brs_pkg::RST_SEL_SECOND;
    else
      sel_second_q <= sel_second_d;
  end

  // ----------------------------------------------------------------
  // standards, reference and monitor path
  // ----------------------------------------------------------------
  brs_pkg::brs_std_t std_first;
  brs_pkg::brs_std_t std_second;
  brs_pkg::brs_route_t route_d;
  brs_pkg::brs_ref_t ref_d;

  assign std_first  = !first_good ? brs_pkg::BRS_STD_NONE
                    : stat_first_in.rate_hd ? brs_pkg::BRS_STD_HD : brs_pkg::BRS_STD_SD;
  assign std_second = !second_good ? brs_pkg::BRS_STD_NONE
                    : stat_second_in.rate_hd ? brs_pkg::BRS_STD_HD : brs_pkg::BRS_STD_SD;
  assign ref_d = !ref_present_in ? brs_pkg::BRS_REF_NONE
               : ref_tri_level_in ? brs_pkg::BRS_REF_TRI : brs_pkg::BRS_REF_BLACK;

  // routing word from the next selection, sel_second_d, not the registered one
  always_comb
  begin
    route_d.pgm_second     = sel_second_d;
    route_d.prev_second    = !sel_second_d;
    route_d.pgm_std        = sel_second_d ? std_second : std_first;
    route_d.prev_std       = sel_second_d ? std_first : std_second;
    route_d.mon_bypass     = (route_d.pgm_std != brs_pkg::BRS_STD_HD) &&
                             (route_d.prev_std != brs_pkg::BRS_STD_HD);
    route_d.mon_pgm_audio  = sel_second_d ? stat_second_in.audio : stat_first_in.audio;
    route_d.mon_prev_audio = sel_second_d ? stat_first_in.audio : stat_second_in.audio;
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      route_out              <= '0;
      ref_type_out           <= brs_pkg::BRS_REF_NONE;
      program_output_sel_out <= 3'h0;
      tally_first_out        <= 1'b0;
      tally_second_out       <= 1'b0;
    end
    else
    begin
      route_out              <= route_d;
      ref_type_out           <= ref_d;
      program_output_sel_out <= {3{sel_second_d}}; // all three follow
      tally_first_out        <= !sel_second_d;
      tally_second_out       <= sel_second_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_tally_onehot: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    $past(rst_n) |-> (tally_first_out != tally_second_out))
    else $error("tallies not one-hot");
  chk_tally_route: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    tally_second_out == route_out.pgm_second)
    else $error("tally disagrees with route");
  chk_prev_other: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    $past(rst_n) |-> route_out.prev_second != route_out.pgm_second)
    else $error("preview equals program");
  chk_pgm_fanout: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    program_output_sel_out == {3{route_out.pgm_second}})
    else $error("program outputs differ");
  chk_manual_first: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (!auto_mode_q && first_press) |=> tally_first_out)
    else $error("manual first ignored");
  chk_manual_second: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (!auto_mode_q && !first_press && second_press) |=> tally_second_out)
    else $error("manual second ignored");
  chk_force_first: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (auto_mode_q && force_first) |=> !route_out.pgm_second)
    else $error("force first ignored");
  chk_force_second: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (auto_mode_q && force_second) |=> route_out.pgm_second)
    else $error("force second ignored");
  chk_auto_kept: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (auto_mode_q && first_active == second_active) |=>
      route_out.pgm_second == $past(auto_second))
    else $error("auto switching lost");
  chk_mon_bypass: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    route_out.mon_bypass |-> (route_out.pgm_std != brs_pkg::BRS_STD_HD) &&
      (route_out.prev_std != brs_pkg::BRS_STD_HD))
    else $error("bypass with hd");

  cov_manual_swap: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
    !auto_mode_q && second_press ##1 tally_second_out);
  cov_auto_force: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
    auto_mode_q && force_second);
  cov_auto_fail: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
    auto_mode_q && !first_good && second_good ##1 tally_second_out);
  cov_hd_route: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
    route_out.pgm_std == brs_pkg::BRS_STD_HD);
endmodule

// >>> tb/brs_contact_model.sv
// contact closure model: switch to ground on an active-low input with pull-up
module brs_contact_model (
  input  wire logic sys_clk_in,
  input  wire logic close_in,
  output logic      contact_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // contact
  // ----------------------------------------------------------------
  // open contact floats to the pull-up level, closed contact grounds it
  assign contact_n_out = close_in ? 1'b0 : 1'b1;
endmodule

// >>> tb/brs_select_ctrl_tb.sv
// testbench: selection control against a behavioural routing model
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: mismatch on line %0d", $time, `__LINE__); end end
module brs_select_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  sys_clk_in = 1'b0;
  logic                  reset_n_in = 1'b0;
  logic                  close_first = 1'b0;
  logic                  close_second = 1'b0;
  logic                  mode_auto = 1'b0;
  brs_pkg::brs_in_stat_t stat1 = 4'hf;
  brs_pkg::brs_in_stat_t stat2 = 4'hf;
  logic                  ref_present = 1'b0;
  logic                  ref_tri = 1'b0;
  logic                  sel_first_n;
  logic                  sel_second_n;
  brs_pkg::brs_route_t   route;
  brs_pkg::brs_ref_t     ref_type;
  logic [2:0]            pgm_sel;
  logic                  tally1;
  logic                  tally2;
  logic                  exp_sec = 1'b0;
  logic                  tally_prev = 1'b0;
  logic                  exp_q[$];        // selection changes still to be seen
  int                    failures = 0;
  int                    num_checks = 0;
  int                    cycles = 0;
  // ----------------------------------------------------------------
  // clock, partners and design
  // ----------------------------------------------------------------
  initial forever #50 sys_clk_in = ~sys_clk_in;
  brs_contact_model u_first (.sys_clk_in(sys_clk_in), .close_in(close_first),
    .contact_n_out(sel_first_n));
  brs_contact_model u_second (.sys_clk_in(sys_clk_in), .close_in(close_second),
    .contact_n_out(sel_second_n));
  brs_select_ctrl u_brs_select_ctrl (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .select_first_in(sel_first_n), .select_second_in(sel_second_n),
    .switch_mode_setting_in(mode_auto), .stat_first_in(stat1), .stat_second_in(stat2),
    .ref_present_in(ref_present), .ref_tri_level_in(ref_tri), .route_out(route),
    .ref_type_out(ref_type), .program_output_sel_out(pgm_sel),
    .tally_first_out(tally1), .tally_second_out(tally2));
  // ----------------------------------------------------------------
  // model and checks
  // ----------------------------------------------------------------
  function automatic brs_pkg::brs_std_t std_of(brs_pkg::brs_in_stat_t s);
    if (!s.valid)
      return brs_pkg::BRS_STD_NONE;
    return s.rate_hd ? brs_pkg::BRS_STD_HD : brs_pkg::BRS_STD_SD;
  endfunction
  task automatic check_all();
    brs_pkg::brs_in_stat_t sp;
    brs_pkg::brs_in_stat_t sv;
    brs_pkg::brs_ref_t     er;
    logic                  eb;
    @(negedge sys_clk_in);
    sp = exp_sec ? stat2 : stat1;
    sv = exp_sec ? stat1 : stat2;
    er = !ref_present ? brs_pkg::BRS_REF_NONE
       : ref_tri ? brs_pkg::BRS_REF_TRI : brs_pkg::BRS_REF_BLACK;
    eb = (std_of(sp) != brs_pkg::BRS_STD_HD) && (std_of(sv) != brs_pkg::BRS_STD_HD);
    `CHK(route.pgm_second, exp_sec)
    `CHK(pgm_sel, {3{exp_sec}})
    `CHK(route.prev_second, ~exp_sec)
    `CHK({tally1, tally2}, {~exp_sec, exp_sec})
    `CHK(route.pgm_std, std_of(sp))
    `CHK(route.prev_std, std_of(sv))
    `CHK(ref_type, er)
    `CHK(route.mon_bypass, eb)
    `CHK({route.mon_pgm_audio, route.mon_prev_audio}, {sp.audio, sv.audio})
    // hand back on a rising edge so that callers drive their inputs there
    @(posedge sys_clk_in);
  endtask
  // wait a bounded time for the tallies to show the expected source
  task automatic wait_sel(input logic sec);
    int n;
    exp_sec = sec;
    exp_q.push_back(sec);
    for (n = 0; n < 40 && tally2 !== sec; n++)
      @(negedge sys_clk_in);
    if (n == 40)
    begin
      failures++;
      $display("Error %0t: selection did not change", $time);
    end
    repeat (2) @(posedge sys_clk_in);
    check_all();
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  // every tally change must be one that the model expects, one per activation
  always @(posedge sys_clk_in)
  begin
    if (reset_n_in && tally_prev !== tally2)
    begin
      if (exp_q.size() == 0)
        `CHK(tally2, tally_prev)
      else
        `CHK(tally2, exp_q.pop_front())
    end
    tally_prev <= tally2;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hf28d));
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    check_all();
    // manual: press second, hold long, one change only
    @(posedge sys_clk_in) close_second <= 1'b1;
    wait_sel(1'b1);
    repeat (60) @(posedge sys_clk_in);
    close_second <= 1'b0;
    repeat (40) @(posedge sys_clk_in);
    check_all();
    // short glitch on first is ignored
    close_first <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    close_first <= 1'b0;
    repeat (40) @(posedge sys_clk_in);
    check_all();
    close_first <= 1'b1;
    wait_sel(1'b0);
    @(posedge sys_clk_in) close_first <= 1'b0;
    // random status and reference levels
    for (int i = 0; i < 24; i++)
    begin
      @(posedge sys_clk_in);
      {stat1, stat2, ref_present, ref_tri} <= 10'($urandom);
      repeat (3) @(posedge sys_clk_in);
      check_all();
      if (i == 11)
      begin
        @(posedge sys_clk_in) close_second <= 1'b1;
        wait_sel(1'b1);
        @(posedge sys_clk_in) close_second <= 1'b0;
        repeat (30) @(posedge sys_clk_in);
      end
    end
    @(posedge sys_clk_in) close_first <= 1'b1;
    wait_sel(1'b0);
    // automatic mode: forced routing ignores quality
    @(posedge sys_clk_in) close_first <= 1'b0;
    mode_auto <= 1'b1;
    stat1 <= 4'h9;
    stat2 <= 4'ha;
    repeat (40) @(posedge sys_clk_in);
    close_second <= 1'b1;
    wait_sel(1'b1);
    stat2 <= 4'h0;
    repeat (10) @(posedge sys_clk_in);
    check_all();
    // both open: automatic choice returns to the good input
    close_second <= 1'b0;
    wait_sel(1'b0);
    // both closed: automatic choice still active
    @(posedge sys_clk_in);
    close_first <= 1'b1;
    close_second <= 1'b1;
    stat1 <= 4'h2;
    stat2 <= 4'hd;
    wait_sel(1'b1);
    repeat (40) @(posedge sys_clk_in);
    check_all();
    // both still closed: status alone moves program back to input one
    stat1 <= 4'h9;
    stat2 <= 4'h0;
    wait_sel(1'b0);
    `CHK(exp_q.size(), 0)
    print_verdict();
  end
endmodule
